/* design/spdif_status_pkg.sv */
// Package with the register map, field layout and reset values of the status builder.
`default_nettype none

package spdif_status_pkg;

    // Register offsets are word indices; the byte address is four times the index.
    localparam logic [5:0] IDX_CONTROL  = 6'h1e;
    localparam logic [5:0] IDX_FORMAT   = 6'h1f;
    localparam logic [5:0] IDX_CATEGORY = 6'h20;
    localparam logic [5:0] IDX_SRC_CHAN = 6'h21;
    localparam logic [5:0] IDX_RATE_ACC = 6'h22;
    localparam logic [5:0] IDX_WORD_LEN = 6'h23;
    localparam logic [5:0] IDX_STATE    = 6'h3f;

    localparam logic [7:0] RST_CONTROL  = 8'h00;
    localparam logic [7:0] RST_FORMAT   = 8'h00;
    localparam logic [7:0] RST_CATEGORY = 8'h00;
    localparam logic [7:0] RST_SRC_CHAN = 8'h00;
    localparam logic [7:0] RST_RATE_ACC = 8'h31;
    localparam logic [7:0] RST_WORD_LEN = 8'h0b;
    localparam logic [7:0] CONTROL_MASK = 8'h07;

    // Control register fields.
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned CTRL_OVW_BIT = 2;

    // Fields of the source/channel, rate/accuracy and word length registers.
    localparam int unsigned SC_SOURCE_NUMBER_LSB = 0;
    localparam int unsigned SC_CH1_LSB    = 4;
    localparam int unsigned SC_CH2_LSB    = 6;
    localparam int unsigned RA_SAMPLE_RATE_CODE_LSB   = 0;
    localparam int unsigned RA_CLK_LSB    = 4;
    localparam int unsigned WL_MAX_BIT    = 0;
    localparam int unsigned WL_LEN_LSB    = 1;
    localparam int unsigned WL_ORIG_LSB   = 4;

    // Source selections.
    localparam logic [1:0] SRC_RECEIVER  = 2'h0;

    // Channel number patterns sent on status bits 23:20.
    localparam logic [3:0] CHAN_NONE  = 4'h0;
    localparam logic [3:0] CHAN_LEFT  = 4'h1;
    localparam logic [3:0] CHAN_RIGHT = 4'h2;

    // Block geometry.
    localparam logic [7:0] LAST_FRAME = 8'hbf;
    localparam logic [7:0] PROG_BITS  = 8'h28;
    localparam int unsigned CS_W      = 40;

    // One outgoing sub-frame as it leaves the builder.
    typedef struct packed {
        logic        block_start;
        logic        subframe;
        logic [23:0] audio;
        logic        validity;
        logic        user;
        logic        status;
        logic        parity;
    } sub_word_s;

    localparam int unsigned SUB_W = $bits(sub_word_s);

endpackage

`default_nettype wire

/* design/sub_stream_if.sv */
// Interface carrying one valid/ready word stream between the builder and its buffer.
`default_nettype none

interface sub_stream_if #(parameter int unsigned W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

`default_nettype wire

/* design/status_buffer2.sv */
// Two-entry buffer that holds finished sub-frames until the serialiser takes them.
`default_nettype none

module status_buffer2
    #(parameter int unsigned W = 8)
    (
    input  wire logic    pclk,
    input  wire logic    presetn,
    sub_stream_if.sink   push,
    sub_stream_if.source pop
    );

    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic              wr_ptr;
        logic              rd_ptr;
        logic [1:0]        count;
    } buf_s;

    buf_s st_reg;
    buf_s st_next;
    logic do_push;
    logic do_pop;

    assign push.ready = (st_reg.count != 2'h2);
    assign pop.valid  = (st_reg.count != 2'h0);
    assign pop.data   = st_reg.slot[st_reg.rd_ptr];
    assign do_push    = push.valid && push.ready;
    assign do_pop     = pop.valid && pop.ready;

    always_comb begin
        st_next = st_reg;
        if (do_push) begin
            st_next.slot[st_reg.wr_ptr] = push.data;
            st_next.wr_ptr = ~st_reg.wr_ptr;
        end
        if (do_pop) begin
            st_next.rd_ptr = ~st_reg.rd_ptr;
        end
        if (do_push && !do_pop) begin
            st_next.count = st_reg.count + 2'h1;
        end else if (do_pop && !do_push) begin
            st_next.count = st_reg.count - 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // status_buffer2

`default_nettype wire

/* design/spdif_status_tx.sv */
// Channel status builder for the S/PDIF transmitter with its APB register bank.
//
// Added by the designer: the APB register port.
`default_nettype none

module spdif_status_tx
    import spdif_status_pkg::*;
    (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic        in_block_start,
    input  wire logic        in_subframe,
    input  wire logic [23:0] in_audio,
    input  wire logic        in_validity,
    input  wire logic        in_user,
    input  wire logic        in_rx_status,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic             out_block_start,
    output logic             out_subframe,
    output logic [23:0]      out_audio,
    output logic             out_validity,
    output logic             out_user,
    output logic             out_status,
    output logic             out_parity,
    output logic [1:0]       data_source_sel
    );

    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  format;
        logic [7:0]  category;
        logic [7:0]  src_chan;
        logic [7:0]  rate_acc;
        logic [7:0]  word_len;
        logic [7:0]  bit_index;
        logic        index_valid;
        logic        ack;
        logic [31:0] rdata;
    } state_s;

    state_s st_reg;
    state_s st_next;

    sub_stream_if #(.W(SUB_W)) push_if ();
    sub_stream_if #(.W(SUB_W)) pop_if ();

    // Bus decode.
    logic [5:0]  reg_word;
    logic        aligned;
    logic        hit;
    logic        apb_access;
    logic        apb_done;
    logic [31:0] read_mux;

    // Sub-frame path.
    logic        accept;
    logic [1:0]  src_sel;
    logic        overwrite;
    logic        pass_recovered;
    logic [7:0]  cur_index;
    logic [CS_W-1:0] block_vec;
    logic        reg_bit;
    logic        status_bit;
    logic        validity_bit;
    logic        user_bit;
    sub_word_s   word;
    sub_word_s   pop_word;

    // Channel number pattern for a two-bit code.
    function automatic logic [3:0] chan_map(input logic [1:0] code);
        logic [3:0] pat;
        pat = CHAN_NONE;
        unique case (code)
            2'h1: pat = CHAN_LEFT;
            2'h2: pat = CHAN_RIGHT;
            2'h0: pat = CHAN_NONE;
            2'h3: pat = CHAN_NONE;
        endcase
        return pat;
    endfunction

    // Programmable part of the block for one sub-frame; only bits 23:20 depend on it.
    function automatic logic [CS_W-1:0] build_block(input state_s s, input logic sub);
        logic [CS_W-1:0] v;
        logic [1:0]      chan_code;
        v = '0;
        chan_code = sub ? s.src_chan[SC_CH2_LSB +: 2] : s.src_chan[SC_CH1_LSB +: 2];
        v[2:0]   = s.format[2:0];
        v[5:3]   = s.format[5:3];
        v[7:6]   = s.format[7:6];
        v[15:8]  = s.category;
        v[19:16] = s.src_chan[SC_SOURCE_NUMBER_LSB +: 4];
        v[23:20] = chan_map(chan_code);
        v[27:24] = s.rate_acc[RA_SAMPLE_RATE_CODE_LSB +: 4];
        v[29:28] = s.rate_acc[RA_CLK_LSB +: 2];
        v[32]    = s.word_len[WL_MAX_BIT];
        v[35:33] = s.word_len[WL_LEN_LSB +: 3];
        v[39:36] = s.word_len[WL_ORIG_LSB +: 4];
        return v;
    endfunction

    // APB decode; every register is one aligned word.
    assign reg_word   = paddr[7:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign apb_access = psel && penable;
    assign apb_done   = apb_access && st_reg.ack;

    always_comb begin
        hit = 1'b0;
        if (aligned) begin
            unique case (reg_word)
                IDX_CONTROL,
                IDX_FORMAT,
                IDX_CATEGORY,
                IDX_SRC_CHAN,
                IDX_RATE_ACC,
                IDX_WORD_LEN,
                IDX_STATE: hit = 1'b1;
                default:   hit = 1'b0;
            endcase
        end
    end

    always_comb begin
        read_mux = 32'h0;
        if (aligned) begin
            unique case (reg_word)
                IDX_CONTROL:  read_mux = {24'h0, st_reg.control};
                IDX_FORMAT:   read_mux = {24'h0, st_reg.format};
                IDX_CATEGORY: read_mux = {24'h0, st_reg.category};
                IDX_SRC_CHAN: read_mux = {24'h0, st_reg.src_chan};
                IDX_RATE_ACC: read_mux = {24'h0, st_reg.rate_acc};
                IDX_WORD_LEN: read_mux = {24'h0, st_reg.word_len};
                IDX_STATE:    read_mux = {23'h0, st_reg.index_valid, st_reg.bit_index};
                default:      read_mux = 32'h0;
            endcase
        end
    end

    // The answer waits one cycle so that read data can come straight from a flip-flop.
    assign pready  = apb_done;
    assign pslverr = apb_done && !hit;
    assign prdata  = st_reg.rdata;

    // Source selection and the status bit for the sub-frame at the input.
    assign src_sel         = st_reg.control[CTRL_SRC_LSB +: 2];
    assign overwrite       = st_reg.control[CTRL_OVW_BIT];
    assign data_source_sel = src_sel;
    assign pass_recovered  = (src_sel == SRC_RECEIVER) && !overwrite;

    // A block start restarts the count on the frame that carries it.
    assign cur_index = in_block_start ? 8'h00 : st_reg.bit_index;
    assign block_vec = build_block(st_reg, in_subframe);

    always_comb begin
        reg_bit = 1'b0;
        if (cur_index < PROG_BITS) begin
            reg_bit = block_vec[cur_index[5:0]];
        end else begin
            reg_bit = 1'b0;
        end
    end

    // Validity and user data are only carried over from the receiver path.
    always_comb begin
        if (src_sel == SRC_RECEIVER) begin
            validity_bit = in_validity;
            user_bit     = in_user;
        end else begin
            validity_bit = 1'b0;
            user_bit     = 1'b0;
        end
    end

    assign status_bit = pass_recovered ? in_rx_status : reg_bit;

    always_comb begin
        word             = '0;
        word.block_start = in_block_start;
        word.subframe    = in_subframe;
        word.audio       = in_audio;
        word.validity    = validity_bit;
        word.user        = user_bit;
        word.status      = status_bit;
        word.parity      = ^{in_audio, validity_bit, user_bit, status_bit};
    end

    // A stalled serialiser holds the input back instead of dropping a sub-frame.
    assign push_if.valid = in_valid;
    assign push_if.data  = word;
    assign in_ready      = push_if.ready;
    assign accept        = in_valid && push_if.ready;

    status_buffer2 #(.W(SUB_W)) status_buffer2_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .push    (push_if.sink),
        .pop     (pop_if.source)
    );

    assign pop_if.ready    = out_ready;
    assign out_valid       = pop_if.valid;
    assign pop_word        = pop_if.data;
    assign out_block_start = pop_word.block_start;
    assign out_subframe    = pop_word.subframe;
    assign out_audio       = pop_word.audio;
    assign out_validity    = pop_word.validity;
    assign out_user        = pop_word.user;
    assign out_status      = pop_word.status;
    assign out_parity      = pop_word.parity;

    always_comb begin
        st_next     = st_reg;
        st_next.ack = 1'b0;

        // First access cycle: capture read data, answer on the next one.
        if (apb_access && !st_reg.ack) begin
            st_next.ack   = 1'b1;
            st_next.rdata = read_mux;
        end

        // Writes land only on the edge that completes the transfer.
        if (apb_done && pwrite && hit) begin
            unique case (reg_word)
                IDX_CONTROL:  st_next.control  = pwdata[7:0] & CONTROL_MASK;
                IDX_FORMAT:   st_next.format   = pwdata[7:0];
                IDX_CATEGORY: st_next.category = pwdata[7:0];
                IDX_SRC_CHAN: st_next.src_chan = pwdata[7:0];
                IDX_RATE_ACC: st_next.rate_acc = pwdata[7:0];
                IDX_WORD_LEN: st_next.word_len = pwdata[7:0];
                default:      st_next.control  = st_reg.control;
            endcase
        end

        // Both sub-frames of a frame share one index; it steps after the second.
        if (accept) begin
            if (in_block_start) begin
                st_next.index_valid = 1'b1;
            end
            if (in_subframe) begin
                if (cur_index == LAST_FRAME) begin
                    st_next.bit_index = 8'h00;
                end else begin
                    st_next.bit_index = cur_index + 8'h01;
                end
            end else begin
                st_next.bit_index = cur_index;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg             <= '0;
            st_reg.control     <= RST_CONTROL;
            st_reg.format      <= RST_FORMAT;
            st_reg.category    <= RST_CATEGORY;
            st_reg.src_chan    <= RST_SRC_CHAN;
            st_reg.rate_acc    <= RST_RATE_ACC;
            st_reg.word_len    <= RST_WORD_LEN;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule // spdif_status_tx

`default_nettype wire

/* dv/spdif_status_tx_chk.sv */
// Port-level assertions for the channel status builder.
`default_nettype none

module spdif_status_tx_chk
    import spdif_status_pkg::*;
    (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        in_valid,
    input wire logic        in_ready,
    input wire logic        in_rx_status,
    input wire logic        out_valid,
    input wire logic        out_ready,
    input wire logic [23:0] out_audio,
    input wire logic        out_validity,
    input wire logic        out_user,
    input wire logic        out_status,
    input wire logic        out_parity,
    input wire logic [1:0]  data_source_sel
    );
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] ctrl_q;
    logic       ctrl_wr;
    logic       rx_pass;
    logic       push_empty;

    // The control register is shadowed from completed writes, since its overwrite bit has no pin.
    assign ctrl_wr = psel && penable && pready && pwrite && !pslverr
                     && paddr == {IDX_CONTROL, 2'b00};
    assign rx_pass = ctrl_q[1:0] == SRC_RECEIVER && !ctrl_q[CTRL_OVW_BIT];
    assign push_empty = in_valid && in_ready && !out_valid;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 3'h0;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_parity_even: assert property (
        out_valid |-> out_parity == ^{out_audio, out_validity, out_user, out_status})
        else $error("parity bit does not give even parity");
    a_rx_status_pass: assert property (
        push_empty && rx_pass |=> out_valid && out_status == $past(in_rx_status))
        else $error("recovered status bit not passed through");
    a_vu_forced_zero: assert property (
        push_empty && ctrl_q[1:0] != SRC_RECEIVER |=> out_valid && !out_validity && !out_user)
        else $error("validity or user bit sent with a non-receiver source");
    a_hold_on_stall: assert property (
        out_valid && !out_ready |=> out_valid && $stable({out_audio, out_status, out_parity}))
        else $error("output word changed while stalled");
    a_source_sel_track: assert property (
        data_source_sel == ctrl_q[1:0])
        else $error("source select differs from the written control value");
    a_access_wait: assert property (
        psel && !penable |=> !pready ##1 pready)
        else $error("answer not in the second access cycle");
    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_error_unaligned: assert property (
        psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("unaligned access not refused");
endmodule // spdif_status_tx_chk

bind spdif_status_tx spdif_status_tx_chk spdif_status_tx_chk_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .in_valid, .in_ready, .in_rx_status, .out_valid, .out_ready, .out_audio,
    .out_validity, .out_user, .out_status, .out_parity, .data_source_sel);

`default_nettype wire

/* dv/status_sink_model.sv */
// Downstream consumer model that takes finished sub-frames, promptly or with stalls.
`default_nettype none

module status_sink_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow,
    output var  logic out_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // A slow consumer takes about one word in four, so the buffer fills and refuses input.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !slow || ($urandom_range(3) == 0);
        end
    end
endmodule // status_sink_model

`default_nettype wire

/* dv/test_spdif_status_tx.sv */
// Self-checking bench for the channel status builder.
`default_nettype none

module test_spdif_status_tx
    import spdif_status_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic in_valid = 1'b0, in_block_start = 1'b0, in_subframe = 1'b0, in_validity = 1'b0;
    logic in_user = 1'b0, in_rx_status = 1'b0;
    logic pready, pslverr, in_ready, out_valid, out_ready, out_block_start, out_subframe;
    logic out_validity, out_user, out_status, out_parity;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [23:0] in_audio = 24'h0, out_audio;
    logic [1:0]  data_source_sel;
    int          fails = 0, samples_checked = 0;
    logic [7:0]  regv [6];
    logic [7:0]  cnt = 8'h00;
    sub_word_s   expq [$];
    sub_word_s   got_w;
    logic [5:0]  ridx [6] = '{IDX_CONTROL, IDX_FORMAT, IDX_CATEGORY, IDX_SRC_CHAN,
                              IDX_RATE_ACC, IDX_WORD_LEN};
    logic [7:0]  rst_tab [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0b};

    assign got_w = {out_block_start, out_subframe, out_audio, out_validity, out_user,
                    out_status, out_parity};

    always #10 pclk = ~pclk;

    spdif_status_tx spdif_status_tx_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_block_start,
        .in_subframe, .in_audio, .in_validity, .in_user, .in_rx_status, .out_valid,
        .out_ready, .out_block_start, .out_subframe, .out_audio, .out_validity, .out_user,
        .out_status, .out_parity, .data_source_sel);
    status_sink_model status_sink_model_inst (.pclk, .presetn, .slow, .out_ready);

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fails == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // A wait that runs out counts as a mismatch instead of hanging the run.
    task automatic wait_hi(input bit for_stream);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((for_stream ? in_ready : pready) !== 1'b1 && n < 64);
        if ((for_stream ? in_ready : pready) !== 1'b1) fails++;
    endtask

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        wait_hi(1'b0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic sub_word_s make_word(logic bs, logic sf, logic [23:0] a, logic v,
                                            logic u, logic rx, logic [7:0] idx);
        logic [39:0] blk;
        logic [1:0]  cc;
        logic        st;
        logic        pass;
        cc = sf ? regv[3][7:6] : regv[3][5:4];
        blk = {regv[5][7:4], regv[5][3:1], regv[5][0], 2'b00, regv[4][5:4], regv[4][3:0],
               cc == 2'b01 ? 4'h1 : cc == 2'b10 ? 4'h2 : 4'h0,
               regv[3][3:0], regv[2], regv[1]};
        pass = regv[0][1:0] == 2'b00;
        st = (pass && !regv[0][2]) ? rx : (idx < 8'h28 ? blk[idx] : 1'b0);
        return '{bs, sf, a, v & pass, u & pass, st, ^{a, v & pass, u & pass, st}};
    endfunction

    task automatic run_stream(input bit mid);
        logic [7:0]  cur;
        logic        bs;
        logic [23:0] a;
        logic [2:0]  vur;
        cur = 8'h00;
        for (int k = 0; k < 400; k++) begin
            bs = !k[0] && (k == 0 || (mid && k == 300));
            if (!k[0]) cur = bs ? 8'h00 : cnt;
            a = 24'($urandom);
            vur = 3'($urandom);
            expq.push_back(make_word(bs, k[0], a, vur[0], vur[1], vur[2], cur));
            in_valid <= 1'b1;
            in_block_start <= bs;
            in_subframe <= k[0];
            in_audio <= a;
            {in_rx_status, in_user, in_validity} <= vur;
            wait_hi(1'b1);
            if (k[0]) cnt = (cur == 8'hbf) ? 8'h00 : cur + 8'h01;
        end
        in_valid <= 1'b0;
        for (int n = 0; n < 999 && expq.size() != 0; n++) @(posedge pclk);
        check("words left", 0, expq.size());
    endtask

    always @(posedge pclk) begin
        if (presetn && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (expq.size() == 0) check("extra word", 0, 1);
            else check("sub-frame", expq.pop_front(), got_w);
        end
    end

    initial begin
        logic [31:0] rd;
        logic        err;
        void'($urandom(8212));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("source select", 2'b00, data_source_sel);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, {ridx[i], 2'b00}, 8'h00, rd, err);
            check("reset", 33'(rst_tab[i]), {err, rd});
        end
        apb(1'b1, 8'h7a, 8'h07, rd, err);
        check("unaligned write", 1'b1, err);
        apb(1'b0, 8'h00, 8'h00, rd, err);
        check("unmapped read", 33'h100000000, {err, rd});
        apb(1'b1, {IDX_STATE, 2'b00}, 8'hff, rd, err);
        check("state write", 1'b0, err);
        apb(1'b0, {IDX_STATE, 2'b00}, 8'h00, rd, err);
        check("state after reset", 33'h0, {err, rd});
        apb(1'b0, {IDX_CONTROL, 2'b00}, 8'h00, rd, err);
        check("control", 33'h0, {err, rd});
        for (int c = 0; c < 8; c++) begin
            regv[0] = 8'(c);
            regv[1] = {3'b000, 2'(c), 3'($urandom)};
            regv[2] = 8'($urandom);
            regv[3] = {~2'(c), 2'(c), 4'($urandom)};
            regv[4] = 8'($urandom);
            regv[5] = 8'($urandom);
            for (int i = 0; i < 6; i++) begin
                apb(1'b1, {ridx[i], 2'b00}, regv[i] | (i == 0 ? 8'hf8 : 8'h00), rd, err);
                check("write error", 1'b0, err);
            end
            for (int i = 0; i < 6; i++) begin
                apb(1'b0, {ridx[i], 2'b00}, 8'h00, rd, err);
                check("register", {25'h0, regv[i]}, {err, rd});
            end
            check("source select", regv[0][1:0], data_source_sel);
            slow <= c[0];
            run_stream(c[0]);
            apb(1'b0, {IDX_STATE, 2'b00}, 8'h00, rd, err);
            check("block index", {24'h0, 1'b1, cnt}, {err, rd});
        end
        give_verdict();
    end

    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
endmodule // test_spdif_status_tx

`default_nettype wire
